// ---- rtl/olp_consts.vh ----
`ifndef OLP_CONSTS_VH
`define OLP_CONSTS_VH
// register offsets
`define OLP_OFS_ID      5'h00
`define OLP_OFS_ALB     5'h01
`define OLP_OFS_RLB     5'h02
`define OLP_OFS_AONE    5'h03
`define OLP_OFS_LOSS    5'h04
`define OLP_OFS_DFS     5'h05
`define OLP_OFS_SIGNAL_LOSS_IRQ_ENABLE   5'h06
`define OLP_OFS_DFIE    5'h07
`define OLP_OFS_LOSLAT  5'h08
`define OLP_OFS_DFLAT   5'h09
`define OLP_OFS_SWR     5'h0a
`define OLP_OFS_DLB     5'h0c
`define OLP_OFS_CLRMODE 5'h1e
`define OLP_OFS_BANK    5'h1f
// bank pointer values
`define OLP_BANK_PRI    8'h00
`define OLP_BANK_LINE   8'h01
// field positions
`define OLP_BIT_CWE     0
`define OLP_BIT_GLOBAL_IRQ_MASK    1
`define OLP_ID_IMP      7
`define OLP_ID_PORT_HI  6
`define OLP_ID_PORT_LO  3
`define OLP_ID_REV_HI   2
`define OLP_ID_REV_LO   0
// reset values
`define OLP_RST_BYTE    8'h00
`define OLP_RST_CNT     8'h00
// soft reset timing
`define OLP_SWR_MIN_NS  1000
`define OLP_CLK_NS      10
`endif

// ---- rtl/olp_primary_regs.v ----
// Notes on behaviour
// - id bit 7 shows impedance variant
// - id bits 6..3 give port count
// - id bits 2..0 give silicon revision
// - bit k drives or reports channel k+1
// - analog loopback feeds tx back to rx
// - remote loopback returns rx to tx
// - remote plus digital gives dual loopback
// - all-ones bit forces ones on tx line
// - loss status follows loss condition
// - fault status follows driver short/open
// - loss enable lets loss changes interrupt
// - fault enable lets fault changes interrupt
// - loss latch sets on either edge
// - fault latch sets on either edge
// - clear-on-write off: read clears latch
// - clear-on-write on: written bit clears
// - bank pointer selects bank, resets 00
// - soft reset write, 1us, reads zero
`timescale 1ns/100ps
`default_nettype none
`include "olp_consts.vh"
module olp_primary_regs #(
   parameter       NCH       = 8,
   parameter [0:0] IMP_120   = 1'b0,
   parameter [3:0] PORTS     = 4'h8,
   parameter [2:0] REVISION  = 3'h1,
   parameter       CNT_W     = 8
) (
   input  wire           ref_clk_i,
   input  wire           rst_i,
   input  wire [4:0]     addr_i,
   input  wire           wr_en_i,
   input  wire           rd_en_i,
   input  wire [7:0]     wdata_i,
   output reg  [7:0]     rdata_o,
   output reg            irq_o,
   input  wire [NCH-1:0] los_i,
   input  wire [NCH-1:0] drv_fault_i,
   input  wire [NCH-1:0] sys_tx_i,
   input  wire [NCH-1:0] line_rx_i,
   output reg  [NCH-1:0] line_tx_o,
   output reg  [NCH-1:0] sys_rx_o,
   output reg  [NCH-1:0] dual_loop_o,
   output wire           soft_rst_o
);
   localparam integer SWR_CYC =
      (`OLP_SWR_MIN_NS + `OLP_CLK_NS - 1) / `OLP_CLK_NS;
   localparam [CNT_W-1:0] SWR_CNT = SWR_CYC[CNT_W-1:0];
   localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

   // soft reset stretcher
   reg [CNT_W-1:0] swr_cnt_r;
   reg [CNT_W-1:0] swr_cnt_nxt;
   wire            int_rst;

   // register file
   reg [7:0]     bank_r;
   reg [NCH-1:0] alb_r;
   reg [NCH-1:0] rlb_r;
   reg [NCH-1:0] dlb_r;
   reg [NCH-1:0] aone_r;
   reg [NCH-1:0] signal_loss_irq_enable_r;
   reg [NCH-1:0] dfie_r;
   reg [NCH-1:0] loslat_r;
   reg [NCH-1:0] dflat_r;
   reg [NCH-1:0] loslat_nxt;
   reg [NCH-1:0] dflat_nxt;
   reg           cwe_r;
   reg           global_irq_mask_r;

   // pin synchronisers and status
   reg [NCH-1:0] los_s1_r;
   reg [NCH-1:0] los_s2_r;
   reg [NCH-1:0] los_r;
   reg [NCH-1:0] df_s1_r;
   reg [NCH-1:0] df_s2_r;
   reg [NCH-1:0] df_r;
   reg [NCH-1:0] stx_s1_r;
   reg [NCH-1:0] stx_s2_r;
   reg [NCH-1:0] lrx_s1_r;
   reg [NCH-1:0] lrx_s2_r;

   // decode
   wire pri_bank;
   wire line_bank;
   wire wr_pri;
   wire rd_pri;
   wire sel_bank;
   wire sel_clr;
   reg  [7:0] rd_mux;

   assign int_rst   = rst_i | (swr_cnt_r != `OLP_RST_CNT);
   assign soft_rst_o = swr_cnt_r != `OLP_RST_CNT;
   assign pri_bank  = bank_r == `OLP_BANK_PRI;
   assign line_bank = bank_r == `OLP_BANK_LINE;
   assign sel_bank  = addr_i == `OLP_OFS_BANK;
   assign sel_clr   = line_bank & (addr_i == `OLP_OFS_CLRMODE);
   assign wr_pri    = wr_en_i & pri_bank & ~int_rst;
   assign rd_pri    = rd_en_i & pri_bank & ~int_rst;

   // soft reset counter, cleared only by the hard reset
   always @* begin
      swr_cnt_nxt = swr_cnt_r;
      if (swr_cnt_r != `OLP_RST_CNT) begin
         swr_cnt_nxt = swr_cnt_r - CNT_ONE;
      end else if (wr_pri && addr_i == `OLP_OFS_SWR) begin
         swr_cnt_nxt = SWR_CNT;
      end
   end

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         swr_cnt_r <= `OLP_RST_CNT;
      end else begin
         swr_cnt_r <= swr_cnt_nxt;
      end
   end

   // two-stage synchronisers for pin inputs
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         los_s1_r <= {NCH{1'b0}};
         los_s2_r <= {NCH{1'b0}};
         df_s1_r  <= {NCH{1'b0}};
         df_s2_r  <= {NCH{1'b0}};
         stx_s1_r <= {NCH{1'b0}};
         stx_s2_r <= {NCH{1'b0}};
         lrx_s1_r <= {NCH{1'b0}};
         lrx_s2_r <= {NCH{1'b0}};
      end else begin
         los_s1_r <= los_i;
         los_s2_r <= los_s1_r;
         df_s1_r  <= drv_fault_i;
         df_s2_r  <= df_s1_r;
         stx_s1_r <= sys_tx_i;
         stx_s2_r <= stx_s1_r;
         lrx_s1_r <= line_rx_i;
         lrx_s2_r <= lrx_s1_r;
      end
   end

   // latch next values: set wins over clear
   always @* begin
      loslat_nxt = loslat_r;
      dflat_nxt  = dflat_r;
      if (rd_pri && !cwe_r && addr_i == `OLP_OFS_LOSLAT) begin
         loslat_nxt = {NCH{1'b0}};
      end
      if (rd_pri && !cwe_r && addr_i == `OLP_OFS_DFLAT) begin
         dflat_nxt = {NCH{1'b0}};
      end
      if (wr_pri && cwe_r && addr_i == `OLP_OFS_LOSLAT) begin
         loslat_nxt = loslat_r & ~wdata_i[NCH-1:0];
      end
      if (wr_pri && cwe_r && addr_i == `OLP_OFS_DFLAT) begin
         dflat_nxt = dflat_r & ~wdata_i[NCH-1:0];
      end
      loslat_nxt = loslat_nxt | (los_s2_r ^ los_r);
      dflat_nxt  = dflat_nxt | (df_s2_r ^ df_r);
   end

   // status and latches
   always @(posedge ref_clk_i) begin
      if (int_rst) begin
         los_r    <= {NCH{1'b0}};
         df_r     <= {NCH{1'b0}};
         loslat_r <= {NCH{1'b0}};
         dflat_r  <= {NCH{1'b0}};
      end else begin
         los_r    <= los_s2_r;
         df_r     <= df_s2_r;
         loslat_r <= loslat_nxt;
         dflat_r  <= dflat_nxt;
      end
   end

   // writable registers
   always @(posedge ref_clk_i) begin
      if (int_rst) begin
         bank_r  <= `OLP_BANK_PRI;
         alb_r   <= {NCH{1'b0}};
         rlb_r   <= {NCH{1'b0}};
         dlb_r   <= {NCH{1'b0}};
         aone_r  <= {NCH{1'b0}};
         signal_loss_irq_enable_r <= {NCH{1'b0}};
         dfie_r  <= {NCH{1'b0}};
         cwe_r   <= 1'b0;
         global_irq_mask_r  <= 1'b0;
      end else if (wr_en_i) begin
         if (sel_bank) begin
            bank_r <= wdata_i;
         end
         if (sel_clr) begin
            cwe_r  <= wdata_i[`OLP_BIT_CWE];
            global_irq_mask_r <= wdata_i[`OLP_BIT_GLOBAL_IRQ_MASK];
         end
         if (pri_bank) begin
            case (addr_i)
               `OLP_OFS_ALB: begin
                  alb_r <= wdata_i[NCH-1:0];
               end
               `OLP_OFS_RLB: begin
                  rlb_r <= wdata_i[NCH-1:0];
               end
               `OLP_OFS_DLB: begin
                  dlb_r <= wdata_i[NCH-1:0];
               end
               `OLP_OFS_AONE: begin
                  aone_r <= wdata_i[NCH-1:0];
               end
               `OLP_OFS_SIGNAL_LOSS_IRQ_ENABLE: begin
                  signal_loss_irq_enable_r <= wdata_i[NCH-1:0];
               end
               `OLP_OFS_DFIE: begin
                  dfie_r <= wdata_i[NCH-1:0];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // read multiplexer
   always @* begin
      rd_mux = `OLP_RST_BYTE;
      if (sel_bank) begin
         rd_mux = bank_r;
      end else if (sel_clr) begin
         rd_mux[`OLP_BIT_CWE]  = cwe_r;
         rd_mux[`OLP_BIT_GLOBAL_IRQ_MASK] = global_irq_mask_r;
      end else if (pri_bank) begin
         case (addr_i)
            `OLP_OFS_ID: begin
               rd_mux[`OLP_ID_IMP] = IMP_120;
               rd_mux[`OLP_ID_PORT_HI:`OLP_ID_PORT_LO] = PORTS;
               rd_mux[`OLP_ID_REV_HI:`OLP_ID_REV_LO] = REVISION;
            end
            `OLP_OFS_ALB: begin
               rd_mux[NCH-1:0] = alb_r;
            end
            `OLP_OFS_RLB: begin
               rd_mux[NCH-1:0] = rlb_r;
            end
            `OLP_OFS_DLB: begin
               rd_mux[NCH-1:0] = dlb_r;
            end
            `OLP_OFS_AONE: begin
               rd_mux[NCH-1:0] = aone_r;
            end
            `OLP_OFS_LOSS: begin
               rd_mux[NCH-1:0] = los_r;
            end
            `OLP_OFS_DFS: begin
               rd_mux[NCH-1:0] = df_r;
            end
            `OLP_OFS_SIGNAL_LOSS_IRQ_ENABLE: begin
               rd_mux[NCH-1:0] = signal_loss_irq_enable_r;
            end
            `OLP_OFS_DFIE: begin
               rd_mux[NCH-1:0] = dfie_r;
            end
            `OLP_OFS_LOSLAT: begin
               rd_mux[NCH-1:0] = loslat_r;
            end
            `OLP_OFS_DFLAT: begin
               rd_mux[NCH-1:0] = dflat_r;
            end
            default: begin
               rd_mux = `OLP_RST_BYTE;
            end
         endcase
      end
   end

   // read data, interrupt and per-channel data path
   always @(posedge ref_clk_i) begin
      if (int_rst) begin
         rdata_o     <= `OLP_RST_BYTE;
         irq_o       <= 1'b0;
         line_tx_o   <= {NCH{1'b0}};
         sys_rx_o    <= {NCH{1'b0}};
         dual_loop_o <= {NCH{1'b0}};
      end else begin
         if (rd_en_i) begin
            rdata_o <= rd_mux;
         end
         irq_o <= ~global_irq_mask_r & (|(loslat_r & signal_loss_irq_enable_r) |
                             |(dflat_r & dfie_r));
         line_tx_o <= aone_r |
                      (~aone_r & rlb_r & lrx_s2_r) |
                      (~aone_r & ~rlb_r & stx_s2_r);
         sys_rx_o <= (dlb_r & stx_s2_r) |
                     (~dlb_r & alb_r & line_tx_o) |
                     (~dlb_r & ~alb_r & lrx_s2_r);
         dual_loop_o <= rlb_r & dlb_r;
      end
   end
endmodule
`default_nettype wire

// ---- sim/olp_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module olp_checker #(
   parameter NCH = 8
) (
   input wire logic           ref_clk_i,
   input wire logic           rst_i,
   input wire logic [4:0]     addr_i,
   input wire logic           wr_en_i,
   input wire logic           rd_en_i,
   input wire logic [7:0]     rdata_o,
   input wire logic           irq_o,
   input wire logic [NCH-1:0] line_tx_o,
   input wire logic [NCH-1:0] sys_rx_o,
   input wire logic [NCH-1:0] dual_loop_o,
   input wire logic           soft_rst_o
);
   logic [7:0] swr_cnt_r;
   // cycles spent in soft reset
   always @(posedge ref_clk_i) begin
      swr_cnt_r <= (soft_rst_o && !rst_i) ? swr_cnt_r + 8'h01 : 8'h00;
   end
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_held;
      soft_rst_o && $past(soft_rst_o);
   endsequence
   sequence s_quiet;
      rdata_o == 8'h00 && !irq_o;
   endsequence
   sequence s_lines_idle;
      line_tx_o == '0 && sys_rx_o == '0 && dual_loop_o == '0;
   endsequence
   a_swr_cause: assert property ($rose(soft_rst_o) |->
      $past(wr_en_i) && $past(addr_i) == 5'h0a)
      else $error("soft reset without write");
   a_swr_width: assert property ($rose(soft_rst_o) |-> soft_rst_o[*8])
      else $error("soft reset too short");
   a_swr_count: assert property ($fell(soft_rst_o) |-> swr_cnt_r == 8'h64)
      else $error("soft reset length wrong");
   a_swr_quiet: assert property (s_held |-> s_quiet)
      else $error("registers live in soft reset");
   a_swr_lines: assert property (s_held |-> s_lines_idle)
      else $error("data outputs live in soft reset");
   a_irq_after_swr: assert property ($fell(soft_rst_o) |-> !irq_o[*2])
      else $error("interrupt after soft reset");
   a_rd_zero: assert property (
      rd_en_i && addr_i == 5'h0a && !soft_rst_o |=> rdata_o == 8'h00)
      else $error("reset register read not zero");
   a_rd_hold: assert property (
      !rd_en_i && !soft_rst_o |=> $stable(rdata_o) || soft_rst_o)
      else $error("read data moved without read");
endmodule
bind olp_primary_regs olp_checker #(.NCH(NCH)) u_chk (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
   .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rdata_o(rdata_o),
   .irq_o(irq_o), .line_tx_o(line_tx_o), .sys_rx_o(sys_rx_o),
   .dual_loop_o(dual_loop_o), .soft_rst_o(soft_rst_o)
);
`default_nettype wire

// ---- sim/olp_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module olp_host_model (
   input  wire logic       ref_clk_i,
   output var  logic [4:0] addr_o,
   output var  logic       wr_en_o,
   output var  logic       rd_en_o,
   output var  logic [7:0] wdata_o,
   input  wire logic [7:0] rdata_i
);
   initial begin
      addr_o = 5'h00;
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      wdata_o = 8'h00;
   end
   // one-cycle write strobe, bus inverted once released
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_en_o <= 1'b1;
      @(posedge ref_clk_i);
      wr_en_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      addr_o <= a;
      rd_en_o <= 1'b1;
      @(posedge ref_clk_i);
      rd_en_o <= 1'b0;
      addr_o <= ~a;
      #1 d = rdata_i;
   endtask
   task automatic bank(input logic [7:0] v);
      wr(5'h1f, v);
   endtask
endmodule
`default_nettype wire

// ---- sim/tb_olp_primary_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_olp_primary_regs;
   logic        ref_clk_i = 1'b0;
   logic        rst_i;
   logic        wr_en, rd_en, irq, srst;
   logic [4:0]  addr;
   logic [7:0]  wdata, rdata, ltx, srx, dual, v;
   logic [7:0]  los, fault, stx, lrx;
   // offset, write data, expected readback
   logic [23:0] rows [9] = '{24'h01_08_08, 24'h02_14_14, 24'h03_80_80,
      24'h0c_10_10, 24'h06_01_01, 24'h07_02_02, 24'h00_ff_c5,
      24'h04_ff_00, 24'h1e_ff_00};
   int          n_fail = 0, n_compared = 0;
   always #5 ref_clk_i = ~ref_clk_i;
   olp_host_model h (.ref_clk_i(ref_clk_i), .addr_o(addr), .wr_en_o(wr_en),
      .rd_en_o(rd_en), .wdata_o(wdata), .rdata_i(rdata));
   // revision value is arbitrary
   olp_primary_regs #(.IMP_120(1'b1), .REVISION(3'h5)) uut (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr),
      .wr_en_i(wr_en), .rd_en_i(rd_en), .wdata_i(wdata), .rdata_o(rdata),
      .irq_o(irq), .los_i(los), .drv_fault_i(fault), .sys_tx_i(stx),
      .line_rx_i(lrx), .line_tx_o(ltx), .sys_rx_o(srx),
      .dual_loop_o(dual), .soft_rst_o(srst));
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic pins(input logic [7:0] l, input logic [7:0] f);
      @(posedge ref_clk_i);
      los <= l;
      fault <= f;
      repeat (7) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic tally_and_finish;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      tally_and_finish;
   end
   initial begin
      rst_i = 1'b1;
      los = 8'h00;
      fault = 8'h00;
      stx = 8'h00;
      lrx = 8'h00;
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         h.wr(rows[i][20:16], rows[i][15:8]);
         h.rd(rows[i][20:16], v);
         chk("readback", v, rows[i][7:0]);
      end
      @(posedge ref_clk_i);
      stx <= 8'h08;
      lrx <= 8'h04;
      pins(8'h00, 8'h00);
      chk("line_tx", ltx, 8'h8c);
      chk("sys_rx", srx, 8'h0c);
      chk("dual", dual, 8'h10);
      pins(8'h01, 8'h00);
      chk("irq", {7'h00, irq}, 8'h01);
      h.rd(5'h04, v);
      chk("los status", v, 8'h01);
      h.rd(5'h08, v);
      chk("los latch", v, 8'h01);
      h.rd(5'h08, v);
      chk("los latch", v, 8'h00);
      chk("irq", {7'h00, irq}, 8'h00);
      pins(8'h00, 8'h00);
      h.wr(5'h08, 8'h01);
      h.rd(5'h08, v);
      chk("los latch", v, 8'h01);
      h.bank(8'h01);
      h.wr(5'h1e, 8'h01);
      h.bank(8'h00);
      pins(8'h00, 8'h02);
      chk("irq", {7'h00, irq}, 8'h01);
      h.rd(5'h05, v);
      chk("fault status", v, 8'h02);
      h.rd(5'h09, v);
      chk("fault latch", v, 8'h02);
      h.rd(5'h09, v);
      chk("fault latch", v, 8'h02);
      h.wr(5'h09, 8'h00);
      h.rd(5'h09, v);
      chk("fault latch", v, 8'h02);
      h.wr(5'h09, 8'h02);
      h.rd(5'h09, v);
      chk("fault latch", v, 8'h00);
      h.bank(8'h01);
      h.wr(5'h1e, 8'h03);
      pins(8'h00, 8'h00);
      chk("irq", {7'h00, irq}, 8'h00);
      h.rd(5'h1f, v);
      chk("bank", v, 8'h01);
      h.bank(8'h00);
      h.rd(5'h09, v);
      chk("fault latch", v, 8'h02);
      h.wr(5'h0a, 8'hff);
      #1;
      chk("soft reset", {7'h00, srst}, 8'h01);
      repeat (101) @(posedge ref_clk_i);
      #1;
      chk("soft reset", {7'h00, srst}, 8'h00);
      h.rd(5'h0a, v);
      chk("reset reg", v, 8'h00);
      h.rd(5'h03, v);
      chk("all ones", v, 8'h00);
      h.bank(8'h01);
      h.rd(5'h1f, v);
      chk("bank", v, 8'h01);
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      h.rd(5'h1f, v);
      chk("bank", v, 8'h00);
      chk("irq", {7'h00, irq}, 8'h00);
      tally_and_finish;
   end
endmodule
`default_nettype wire
